// ---- src/dramc_defines.svh ----
// Purpose: timing counts, field positions and idle codes of the array control
// Assumes: one 250 MHz clock; times are given in ns and turned into cycles
// Notes: least times round up, the refresh interval rounds down
`ifndef DRAMC_DEFINES_SVH
`define DRAMC_DEFINES_SVH

// clock period
`define DRAMC_CLK_NS 4
// least times, rounded up to whole cycles
`define DRAMC_UP(ns) (((ns) + `DRAMC_CLK_NS - 1) / `DRAMC_CLK_NS)
`define DRAMC_ROW_HOLD_NS 20
`define DRAMC_COL_SET_NS 12
`define DRAMC_CAS_ACC_NS 135
`define DRAMC_PRE_NS 100
`define DRAMC_REF_RAS_NS 240
`define DRAMC_SYNC_STAGES 2
`define DRAMC_ROW_HOLD_CYC `DRAMC_UP(`DRAMC_ROW_HOLD_NS)
`define DRAMC_COL_SET_CYC `DRAMC_UP(`DRAMC_COL_SET_NS)
`define DRAMC_CAS_CYC (`DRAMC_UP(`DRAMC_CAS_ACC_NS) + `DRAMC_SYNC_STAGES + 1)
`define DRAMC_PRE_CYC `DRAMC_UP(`DRAMC_PRE_NS)
`define DRAMC_REF_RAS_CYC `DRAMC_UP(`DRAMC_REF_RAS_NS)
// refresh interval, longest time, rounded down
`define DRAMC_REF_NS 14500
`define DRAMC_REF_CYC (`DRAMC_REF_NS / `DRAMC_CLK_NS)

// word address fields
`define DRAMC_ROW_LSB 0
`define DRAMC_COL_LSB 7
`define DRAMC_BANK_LSB 14
`define DRAMC_HALF_W 7
`define DRAMC_BANK_W 3
`define DRAMC_UPPER_BIT 2
// write strobe lanes
`define DRAMC_WE_LO_LOWER 0
`define DRAMC_WE_LO_UPPER 1
`define DRAMC_WE_HI_LOWER 2
`define DRAMC_WE_HI_UPPER 3
// idle, all-on and one-bank codes
`define DRAMC_RAS_IDLE 8'hff
`define DRAMC_RAS_ALL 8'h00
`define DRAMC_WE_IDLE 4'hf
`define DRAMC_BANK_ONE 8'h01

`endif

// ---- src/dramc_pkg.sv ----
// Purpose: types shared by the array control
// Assumes: nothing
// Notes: states are one-hot
package dramc_pkg;
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ASET = 6'h02,
		ST_RAS = 6'h04,
		ST_COL = 6'h08,
		ST_CAS = 6'h10,
		ST_PRE = 6'h20
	} dramc_state_t;
endpackage : dramc_pkg

// ---- src/dramc_parity.sv ----
// Purpose: parity bit of one data byte
// Assumes: combinational, same clock domain as the user
// Notes: ODD selects odd parity, else even
`timescale 1ns/1ps
module dramc_parity #(
	parameter int W = 8,
	parameter bit ODD = 1'b0
) (
	input wire logic [W-1:0] i_data,
	output logic o_par
);
	// reduction xor, flipped for odd parity
	always_comb begin
		o_par = (^i_data) ^ ODD;
	end
endmodule : dramc_parity

// ---- src/dramc_ctrl.sv ----
// Purpose: row/column strobe sequencing and refresh of a 16K x 1 chip array
// Assumes: user side on i_clk; array data inputs are asynchronous pins
// Notes: first-come arbitration between refresh and data cycles
`timescale 1ns/1ps
`include "dramc_defines.svh"
module dramc_ctrl #(
	parameter int REF_CYC = `DRAMC_REF_CYC,
	parameter int CNT_W = 8,
	parameter bit ODD_PARITY = 1'b0
) (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_req,
	input wire logic i_write,
	input wire logic [1:0] i_byte_en,
	input wire logic [16:0] i_addr,
	input wire logic [15:0] i_wdata,
	output logic o_ready,
	output logic o_done,
	output logic [15:0] o_rdata,
	output logic [1:0] o_rpar,
	output logic [6:0] o_bank_group_a_mux_address,
	output logic [7:0] o_bank_row_strobe_n,
	output logic o_column_strobe_n,
	output logic o_parity_column_strobe_n,
	output logic o_low_byte_write_strobe_lower_banks_n,
	output logic o_low_byte_write_strobe_upper_banks_n,
	output logic o_high_byte_write_strobe_lower_banks_n,
	output logic o_high_byte_write_strobe_upper_banks_n,
	input wire logic [15:0] i_array_data_bus,
	output logic [15:0] o_array_data_bus,
	output logic o_array_data_bus_oe_n,
	output logic o_high_parity_write_in,
	output logic o_low_parity_write_in,
	input wire logic i_high_parity_read_out,
	input wire logic i_low_parity_read_out
);
	localparam int TMR_W = $clog2(REF_CYC);

	// refuse settings the counters cannot hold
	if (REF_CYC < 256 || REF_CYC > 4096) begin : g_bad_ref
		$error("REF_CYC out of range");
	end
	if (`DRAMC_CAS_CYC >= (1 << CNT_W) || CNT_W > 16) begin : g_bad_cnt
		$error("CNT_W too small for the column strobe time");
	end

	dramc_pkg::dramc_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [16:0] addr_ff, nxt_addr;
	logic wr_ff, nxt_wr;
	logic [1:0] be_ff, nxt_be;
	logic [15:0] wdata_ff, nxt_wdata;
	logic [1:0] wpar_ff, nxt_wpar;
	logic is_ref_ff, nxt_is_ref;
	logic mem_pend_ff, nxt_mem_pend;
	logic ref_pend_ff, nxt_ref_pend;
	logic ref_old_ff, nxt_ref_old;
	logic [TMR_W-1:0] ref_tmr_ff, nxt_ref_tmr;
	logic [6:0] ref_row_ff, nxt_ref_row;
	logic ready_ff, nxt_ready;
	logic done_ff, nxt_done;
	logic [15:0] rdata_ff, nxt_rdata;
	logic [1:0] rpar_ff, nxt_rpar;
	logic [6:0] mux_ff, nxt_mux;
	logic [7:0] ras_n_ff, nxt_ras_n;
	logic cas_n_ff, nxt_cas_n;
	logic [3:0] we_n_ff, nxt_we_n;
	logic oe_n_ff, nxt_oe_n;
	logic [17:0] sync1_ff, sync2_ff;
	logic [1:0] gen_par;
	logic take, ref_fire, cnt_zero, upper;
	logic [2:0] bank;

	// one parity bit per data byte
	dramc_parity #(.W(8), .ODD(ODD_PARITY)) u_par_lo (
		.i_data(i_wdata[7:0]),
		.o_par(gen_par[0])
	);
	dramc_parity #(.W(8), .ODD(ODD_PARITY)) u_par_hi (
		.i_data(i_wdata[15:8]),
		.o_par(gen_par[1])
	);

	// two-flop synchroniser for the array read lines
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			sync1_ff <= 18'h00000;
			sync2_ff <= 18'h00000;
		end else begin
			sync1_ff <= {i_high_parity_read_out, i_low_parity_read_out,
				i_array_data_bus};
			sync2_ff <= sync1_ff;
		end
	end

	// sequencer, arbitration and refresh timing
	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_addr = addr_ff;
		nxt_wr = wr_ff;
		nxt_be = be_ff;
		nxt_wdata = wdata_ff;
		nxt_wpar = wpar_ff;
		nxt_is_ref = is_ref_ff;
		nxt_mem_pend = mem_pend_ff;
		nxt_ref_pend = ref_pend_ff;
		nxt_ref_old = ref_old_ff;
		nxt_ref_row = ref_row_ff;
		nxt_done = 1'b0;
		nxt_rdata = rdata_ff;
		nxt_rpar = rpar_ff;
		nxt_mux = mux_ff;
		nxt_ras_n = ras_n_ff;
		nxt_cas_n = cas_n_ff;
		nxt_we_n = we_n_ff;
		nxt_oe_n = oe_n_ff;
		cnt_zero = (cnt_ff == '0);
		bank = addr_ff[`DRAMC_BANK_LSB +: `DRAMC_BANK_W];
		upper = bank[`DRAMC_UPPER_BIT];
		// free-running refresh interval, not held off by data traffic
		ref_fire = (ref_tmr_ff == '0);
		nxt_ref_tmr = ref_fire ? TMR_W'(REF_CYC - 1) : ref_tmr_ff - 1'b1;
		take = i_req && ready_ff;
		if (take) begin
			nxt_mem_pend = 1'b1;
			nxt_addr = i_addr;
			nxt_wr = i_write;
			nxt_be = i_byte_en;
			nxt_wdata = i_wdata;
			nxt_wpar = gen_par;
		end
		if (!cnt_zero) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
		case (state_ff)
			dramc_pkg::ST_IDLE: begin
				// older request wins; a tie goes to refresh
				if (ref_pend_ff && (!mem_pend_ff || ref_old_ff)) begin
					nxt_ref_pend = 1'b0;
					nxt_is_ref = 1'b1;
					nxt_mux = ref_row_ff;
					nxt_state = dramc_pkg::ST_ASET;
				end else if (mem_pend_ff) begin
					nxt_is_ref = 1'b0;
					nxt_mux = addr_ff[`DRAMC_ROW_LSB +: `DRAMC_HALF_W];
					nxt_state = dramc_pkg::ST_ASET;
				end
			end
			dramc_pkg::ST_ASET: begin
				// row half has had a cycle of setup; now the row strobe
				if (is_ref_ff) begin
					nxt_ras_n = `DRAMC_RAS_ALL;
					nxt_cnt = CNT_W'(`DRAMC_REF_RAS_CYC - 1);
				end else begin
					nxt_ras_n = ~(`DRAMC_BANK_ONE << bank);
					nxt_cnt = CNT_W'(`DRAMC_ROW_HOLD_CYC - 1);
				end
				nxt_state = dramc_pkg::ST_RAS;
			end
			dramc_pkg::ST_RAS: begin
				if (cnt_zero && is_ref_ff) begin
					nxt_ras_n = `DRAMC_RAS_IDLE;
					nxt_ref_row = ref_row_ff + 1'b1;
					nxt_cnt = CNT_W'(`DRAMC_PRE_CYC - 1);
					nxt_state = dramc_pkg::ST_PRE;
				end else if (cnt_zero) begin
					nxt_mux = addr_ff[`DRAMC_COL_LSB +: `DRAMC_HALF_W];
					if (wr_ff) begin
						// write strobes and data go out before column strobe
						nxt_oe_n = 1'b0;
						if (be_ff[0]) begin
							nxt_we_n[upper ? `DRAMC_WE_LO_UPPER
								: `DRAMC_WE_LO_LOWER] = 1'b0;
						end
						if (be_ff[1]) begin
							nxt_we_n[upper ? `DRAMC_WE_HI_UPPER
								: `DRAMC_WE_HI_LOWER] = 1'b0;
						end
					end
					nxt_cnt = CNT_W'(`DRAMC_COL_SET_CYC - 1);
					nxt_state = dramc_pkg::ST_COL;
				end
			end
			dramc_pkg::ST_COL: begin
				if (cnt_zero) begin
					nxt_cas_n = 1'b0;
					nxt_cnt = CNT_W'(`DRAMC_CAS_CYC - 1);
					nxt_state = dramc_pkg::ST_CAS;
				end
			end
			dramc_pkg::ST_CAS: begin
				// hold covers access time plus the synchroniser
				if (cnt_zero) begin
					if (!wr_ff) begin
						nxt_rdata = sync2_ff[15:0];
						nxt_rpar = sync2_ff[17:16];
					end
					nxt_ras_n = `DRAMC_RAS_IDLE;
					nxt_cas_n = 1'b1;
					nxt_we_n = `DRAMC_WE_IDLE;
					nxt_oe_n = 1'b1;
					nxt_done = 1'b1;
					nxt_mem_pend = 1'b0;
					nxt_ref_old = 1'b1; // a waiting refresh is now oldest
					nxt_cnt = CNT_W'(`DRAMC_PRE_CYC - 1);
					nxt_state = dramc_pkg::ST_PRE;
				end
			end
			dramc_pkg::ST_PRE: begin
				if (cnt_zero) begin
					nxt_is_ref = 1'b0;
					nxt_state = dramc_pkg::ST_IDLE;
				end
			end
			default: begin
				nxt_state = dramc_pkg::ST_IDLE;
				nxt_ras_n = `DRAMC_RAS_IDLE;
				nxt_cas_n = 1'b1;
				nxt_we_n = `DRAMC_WE_IDLE;
				nxt_oe_n = 1'b1;
			end
		endcase
		// a fresh interval tick wins over the clear at refresh start
		if (ref_fire) begin
			nxt_ref_pend = 1'b1;
			if (!ref_pend_ff) begin
				// older unless a data cycle was pending and still is
				nxt_ref_old = !(mem_pend_ff && nxt_mem_pend);
			end
		end
		if (take && !ref_pend_ff && !ref_fire) begin
			nxt_ref_old = 1'b0;
		end
		nxt_ready = !nxt_mem_pend;
	end

	// register the sequencer state and all outputs
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= dramc_pkg::ST_IDLE;
			cnt_ff <= '0;
			addr_ff <= 17'h00000;
			wr_ff <= 1'b0;
			be_ff <= 2'h0;
			wdata_ff <= 16'h0000;
			wpar_ff <= 2'h0;
			is_ref_ff <= 1'b0;
			mem_pend_ff <= 1'b0;
			ref_pend_ff <= 1'b0;
			ref_old_ff <= 1'b0;
			ref_tmr_ff <= '0;
			ref_row_ff <= 7'h00;
			ready_ff <= 1'b1;
			done_ff <= 1'b0;
			rdata_ff <= 16'h0000;
			rpar_ff <= 2'h0;
			mux_ff <= 7'h00;
			ras_n_ff <= `DRAMC_RAS_IDLE;
			cas_n_ff <= 1'b1;
			we_n_ff <= `DRAMC_WE_IDLE;
			oe_n_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			addr_ff <= nxt_addr;
			wr_ff <= nxt_wr;
			be_ff <= nxt_be;
			wdata_ff <= nxt_wdata;
			wpar_ff <= nxt_wpar;
			is_ref_ff <= nxt_is_ref;
			mem_pend_ff <= nxt_mem_pend;
			ref_pend_ff <= nxt_ref_pend;
			ref_old_ff <= nxt_ref_old;
			ref_tmr_ff <= nxt_ref_tmr;
			ref_row_ff <= nxt_ref_row;
			ready_ff <= nxt_ready;
			done_ff <= nxt_done;
			rdata_ff <= nxt_rdata;
			rpar_ff <= nxt_rpar;
			mux_ff <= nxt_mux;
			ras_n_ff <= nxt_ras_n;
			cas_n_ff <= nxt_cas_n;
			we_n_ff <= nxt_we_n;
			oe_n_ff <= nxt_oe_n;
		end
	end

	// outputs straight from flops
	assign o_ready = ready_ff;
	assign o_done = done_ff;
	assign o_rdata = rdata_ff;
	assign o_rpar = rpar_ff;
	assign o_bank_group_a_mux_address = mux_ff;
	assign o_bank_row_strobe_n = ras_n_ff;
	assign o_column_strobe_n = cas_n_ff;
	assign o_parity_column_strobe_n = cas_n_ff;
	assign o_low_byte_write_strobe_lower_banks_n = we_n_ff[`DRAMC_WE_LO_LOWER];
	assign o_low_byte_write_strobe_upper_banks_n = we_n_ff[`DRAMC_WE_LO_UPPER];
	assign o_high_byte_write_strobe_lower_banks_n = we_n_ff[`DRAMC_WE_HI_LOWER];
	assign o_high_byte_write_strobe_upper_banks_n = we_n_ff[`DRAMC_WE_HI_UPPER];
	assign o_array_data_bus = wdata_ff;
	assign o_array_data_bus_oe_n = oe_n_ff;
	assign o_high_parity_write_in = wpar_ff[1];
	assign o_low_parity_write_in = wpar_ff[0];

	// checks on the array sequencing
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_resetn);

	row_addr_a: assert property (($past(ras_n_ff) == `DRAMC_RAS_IDLE
		&& ras_n_ff != `DRAMC_RAS_IDLE && !is_ref_ff)
		|-> mux_ff == addr_ff[6:0]) else $error("row half wrong");
	col_addr_a: assert property ($fell(cas_n_ff) |-> mux_ff == addr_ff[13:7]
		&& ras_n_ff != `DRAMC_RAS_IDLE) else $error("column bad");
	one_bank_a: assert property (!cas_n_ff |-> ras_n_ff ==
		~(`DRAMC_BANK_ONE << addr_ff[16:14])) else $error("bank");
	read_we_a: assert property ((!cas_n_ff && !wr_ff) |-> we_n_ff ==
		`DRAMC_WE_IDLE) else $error("write strobe low in read");
	write_first_a: assert property (($fell(cas_n_ff) && wr_ff && be_ff != 2'h0)
		|-> $past(we_n_ff) != `DRAMC_WE_IDLE && !oe_n_ff)
		else $error("write strobe late");
	cas_hold_a: assert property ($fell(cas_n_ff) |-> !cas_n_ff[*8])
		else $error("column strobe too short");
	ref_quiet_a: assert property (ras_n_ff == `DRAMC_RAS_ALL |-> cas_n_ff
		&& we_n_ff == `DRAMC_WE_IDLE) else $error("refresh not quiet");
	ref_step_a: assert property (($past(ras_n_ff) == `DRAMC_RAS_ALL
		&& ras_n_ff == `DRAMC_RAS_IDLE) |-> ref_row_ff ==
		7'($past(ref_row_ff) + 1'b1)) else $error("row step");
	ref_start_a: assert property ($rose(ref_pend_ff) |-> ##[1:200]
		ras_n_ff == `DRAMC_RAS_ALL) else $error("refresh late");
	par_gen_a: assert property (take |=> wpar_ff ==
		{^wdata_ff[15:8] ^ ODD_PARITY, ^wdata_ff[7:0] ^ ODD_PARITY})
		else $error("parity wrong");

	read_c: cover property ($fell(cas_n_ff) && !wr_ff);
	write_c: cover property ($fell(cas_n_ff) && wr_ff);
	refresh_c: cover property (ras_n_ff == `DRAMC_RAS_ALL);
	clash_c: cover property (ref_pend_ff && mem_pend_ff);
endmodule : dramc_ctrl

// ---- dv/dramc_array_model.sv ----
// Purpose: behavioural bank array of 16K x 1 chips behind the controller
// Assumes: strobes active low; bank lanes split at bank 4
// Notes: also resolves the shared data wire; a floating wire shows ~last
`timescale 1ns/1ps
module dramc_array_model (
	input wire logic i_slow,
	input wire logic [6:0] i_addr,
	input wire logic [7:0] i_ras_n,
	input wire logic i_cas_n,
	input wire logic [3:0] i_we_n,
	input wire logic [15:0] i_host_data,
	input wire logic i_host_oe_n,
	input wire logic [1:0] i_par_w,
	output logic [15:0] o_bus,
	output logic [1:0] o_par
);
	logic [17:0] mem [0:131071];
	logic [7:0] prev_ras_n = 8'hff;
	logic [2:0] bank = 3'h0;
	logic [6:0] row = 7'h00;
	logic [16:0] loc;
	logic [17:0] q = 18'h0;
	logic [17:0] last = 18'h0;
	logic valid = 1'b0;
	logic lo_w;
	logic hi_w;
	// wire level: block drives, else chip read data, else floating
	assign o_bus = !i_host_oe_n ? i_host_data
		: valid ? q[15:0] : ~last[15:0];
	assign o_par = valid ? q[17:16] : ~last[17:16];
	always @(o_bus or o_par) begin
		if (valid)
			last = {o_par, o_bus};
	end
	// addressed bank latches its row on its own strobe fall
	always @(i_ras_n) begin
		for (int b = 0; b < 8; b++)
			if (prev_ras_n[b] && !i_ras_n[b] && i_ras_n != 8'h00) begin
				bank = b[2:0];
				row = i_addr;
			end
		prev_ras_n = i_ras_n;
	end
	// column fall: store strobed lanes, else start a read
	always @(negedge i_cas_n) begin
		loc = {bank, i_addr, row};
		lo_w = bank[2] ? !i_we_n[1] : !i_we_n[0];
		hi_w = bank[2] ? !i_we_n[3] : !i_we_n[2];
		if (lo_w)
			mem[loc][7:0] = o_bus[7:0];
		if (lo_w)
			mem[loc][16] = i_par_w[0];
		if (hi_w)
			mem[loc][15:8] = o_bus[15:8];
		if (hi_w)
			mem[loc][17] = i_par_w[1];
		if (!lo_w && !hi_w) begin
			q = mem[loc];
			valid <= #(i_slow ? 130 : 20) 1'b1;
		end
	end
	// read data stays only while the column strobe is low
	always @(posedge i_cas_n) valid = 1'b0;
endmodule : dramc_array_model

// ---- dv/testbench.sv ----
// Purpose: self-checking bench of the array control against the chip model
// Assumes: short refresh interval of 256 cycles
// Notes: inputs change at the falling edge; results checked from a queue
`timescale 1ns/1ps
module testbench;
	localparam int REF = 256;
	logic i_clk = 1'b0;
	logic i_resetn = 1'b0;
	logic i_req = 1'b0;
	logic i_write = 1'b0;
	logic [1:0] i_byte_en = 2'h0;
	logic [16:0] i_addr = 17'h0;
	logic [15:0] i_wdata = 16'h0;
	logic slow = 1'b0;
	wire o_ready, o_done, cas_n, pcas_n, oe_n;
	wire [15:0] o_rdata, bus, dout;
	wire [1:0] o_rpar, par_r, par_w;
	wire [6:0] mux;
	wire [7:0] ras_n;
	wire [3:0] we_n;
	int errors = 0;
	int comparisons = 0;
	int refs = 0;
	int since = 0;
	logic [31:0] seed = 32'h45;
	logic [18:0] expq [$];
	logic [18:0] e;
	logic [17:0] shadow [logic [16:0]];
	logic [7:0] cur_ras = 8'hff;
	logic [6:0] cur_row, cur_col, ref_row;
	logic [3:0] cur_we = 4'hf;
	logic [15:0] cur_data;
	logic cur_wr = 1'b0;
	logic [7:0] prev_ras_n = 8'hff;
	logic prev_cas_n = 1'b1;
	dramc_ctrl #(.REF_CYC(REF)) dut (.i_clk, .i_resetn, .i_req, .i_write,
		.i_byte_en, .i_addr, .i_wdata, .o_ready, .o_done, .o_rdata, .o_rpar,
		.o_bank_group_a_mux_address(mux), .o_bank_row_strobe_n(ras_n),
		.o_column_strobe_n(cas_n), .o_parity_column_strobe_n(pcas_n),
		.o_low_byte_write_strobe_lower_banks_n(we_n[0]),
		.o_low_byte_write_strobe_upper_banks_n(we_n[1]),
		.o_high_byte_write_strobe_lower_banks_n(we_n[2]),
		.o_high_byte_write_strobe_upper_banks_n(we_n[3]),
		.i_array_data_bus(bus), .o_array_data_bus(dout),
		.o_array_data_bus_oe_n(oe_n), .o_high_parity_write_in(par_w[1]),
		.o_low_parity_write_in(par_w[0]), .i_high_parity_read_out(par_r[1]),
		.i_low_parity_read_out(par_r[0]));
	dramc_array_model chips (.i_slow(slow), .i_addr(mux), .i_ras_n(ras_n),
		.i_cas_n(cas_n), .i_we_n(we_n), .i_host_data(dout), .i_host_oe_n(oe_n),
		.i_par_w(par_w), .o_bus(bus), .o_par(par_r));
	// clock of 4 ns
	always #2 i_clk = ~i_clk;
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction : xs
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic stop_test();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	// one request; junk keeps a refused request up while busy
	task automatic do_req(input logic wr, input logic [1:0] be,
		input logic [16:0] a, input logic [15:0] d, input logic junk);
		int n;
		@(negedge i_clk);
		i_req = 1'b1;
		i_write = wr;
		i_byte_en = be;
		i_addr = a;
		i_wdata = d;
		n = 0;
		while (o_ready !== 1'b1 && n < 200) begin
			@(negedge i_clk);
			n++;
		end
		if (n >= 200)
			errors++;
		@(posedge i_clk);
		cur_ras = ~(8'h01 << a[16:14]);
		cur_col = a[13:7];
		cur_row = a[6:0];
		cur_wr = wr;
		cur_data = d;
		cur_we = 4'hf;
		cur_we[a[16] ? 1 : 0] = !(wr && be[0]);
		cur_we[a[16] ? 3 : 2] = !(wr && be[1]);
		if (!wr)
			expq.push_back({1'b1, shadow[a]});
		else
			expq.push_back(19'h0);
		if (wr && be[0])
			shadow[a] = {shadow[a][17], ^d[7:0], shadow[a][15:8], d[7:0]};
		if (wr && be[1])
			shadow[a] = {^d[15:8], shadow[a][16], d[15:8], shadow[a][7:0]};
		@(negedge i_clk);
		if (junk) begin
			i_addr = ~a;
			i_write = ~wr;
			repeat (3) @(negedge i_clk);
		end
		i_req = 1'b0;
	endtask : do_req
	// watch results and the array side at the settled falling edge
	always @(negedge i_clk) begin
		if (o_done === 1'b1) begin
			if (expq.size() == 0)
				chk(32'h1, 32'h0);
			else begin
				e = expq.pop_front();
				if (e[18])
					chk({o_rpar, o_rdata}, e[17:0]);
			end
		end
		if (ras_n === 8'h00)
			chk({cas_n, oe_n, we_n}, 6'h3f);
		if (prev_ras_n === 8'hff && ras_n === 8'h00) begin
			ref_row += 7'h1;
			if (refs > 0)
				chk(mux, ref_row);
			if (refs > 0)
				chk(since > REF - 90 && since < REF + 90, 1);
			ref_row = mux;
			refs++;
			since = 0;
		end else
			since++;
		if (prev_ras_n === 8'hff && ras_n !== 8'hff && ras_n !== 8'h00) begin
			chk(ras_n, cur_ras);
			chk(mux, cur_row);
		end
		if (prev_cas_n === 1'b1 && cas_n === 1'b0)
			chk(mux, cur_col);
		if (cas_n === 1'b0) begin
			chk({pcas_n, we_n}, {1'b0, cur_we});
			chk(ras_n, cur_ras);
			if (cur_wr)
				chk({oe_n, dout}, {1'b0, cur_data});
		end
		prev_ras_n = ras_n;
		prev_cas_n = cas_n;
	end
	// watchdog
	initial begin
		repeat (30000) @(posedge i_clk);
		errors++;
		stop_test();
	end
	// main sequence: every bank, every byte-enable code, fast and slow chips
	initial begin
		logic [16:0] a;
		repeat (20) @(posedge i_clk);
		@(negedge i_clk);
		i_resetn = 1'b1;
		chk({o_ready, o_done, ras_n, cas_n, we_n, oe_n}, 16'hbfff);
		for (int i = 0; i < 32; i++) begin
			seed = xs(seed);
			a = {i[2:0], seed[13:0]};
			slow = i[0];
			do_req(1'b1, 2'h3, a, seed[31:16], 1'b0);
			seed = xs(seed);
			do_req(1'b1, i[4:3], a, seed[15:0], i[1]);
			do_req(1'b0, 2'h0, a, 16'h0, 1'b0);
		end
		repeat (3 * REF) @(negedge i_clk);
		chk(refs > 3, 1);
		chk(expq.size(), 0);
		stop_test();
	end
endmodule : testbench
